// ---- design/decade_pkg.sv ----
// shared constants and types for the ripple decade counter
package decade_pkg;

    // width of the divide-by-five section
    localparam int QUINT_W = 3;

    // last state of the divide-by-five section before it wraps
    localparam logic [QUINT_W-1:0] QUINT_LAST = 3'h4;
    // step added to the divide-by-five section on each count
    localparam logic [QUINT_W-1:0] QUINT_STEP = 3'h1;
    // divide-by-five section value after clear and after reset
    localparam logic [QUINT_W-1:0] QUINT_ZERO = 3'h0;
    // divide-by-five part of the preset value nine (high set only)
    localparam logic [QUINT_W-1:0] QUINT_NINE = 3'h4;

    // divide-by-two stage value after clear and after reset
    localparam logic HALVE_ZERO = 1'h0;
    // divide-by-two part of the preset value nine
    localparam logic HALVE_NINE = 1'h1;
    // sampled count input level after reset (no false first edge)
    localparam logic PREV_RESET = 1'h0;

    // four stored stages: divide-by-five bits over the halve bit
    typedef struct packed {
        logic [QUINT_W-1:0] quint; // high, mid, low
        logic halve;               // divide-by-two stage
    } count_t;

    // whole counter value after reset or clear
    localparam count_t COUNT_ZERO = '{quint: QUINT_ZERO, halve: HALVE_ZERO};
    // whole counter value after preset (weight 8 and 1)
    localparam count_t COUNT_NINE = '{quint: QUINT_NINE, halve: HALVE_NINE};

endpackage : decade_pkg

// ---- design/ripple_decade_counter.sv ----
// ripple decade counter: divide-by-two stage plus divide-by-five section
//
// Functional notes
// - four stages: one halver, one divide-by-five section
// - each section counts on its input's falling edge
// - halver output not wired inside to quint section
// - both clears high, no preset: all outputs low
// - both presets high: load nine, overriding clears and counting
// - bcd: halve output wired to quint count input
// - bcd count follows 8421 binary codes
// - bi-quinary: high bit drives halve input externally
// - unwired: halver divides by two alone
`timescale 1ns/10ps

module ripple_decade_counter
    import decade_pkg::*;
(
    // clock, reset and enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic count_enable,
    // count inputs, active on falling edge
    input wire logic halve_count_in,
    input wire logic quint_count_in,
    // gated clear and preset-to-nine levels
    input wire logic clear_in_a,
    input wire logic clear_in_b,
    input wire logic preset_nine_a,
    input wire logic preset_nine_b,
    // counter outputs
    output logic halve_out,
    output logic quint_bit_low,
    output logic quint_bit_mid,
    output logic quint_bit_high
);

    count_t count_ff;          // the four stored stages
    count_t nxt_count;         // next value of the stages
    logic halve_prev_ff;       // last sampled halve count input
    logic quint_prev_ff;       // last sampled quint count input
    logic nxt_halve_prev;      // next halve input sample
    logic nxt_quint_prev;      // next quint input sample
    logic halve_fall;          // falling edge seen on halve input
    logic quint_fall;          // falling edge seen on quint input
    logic preset_on;           // both preset inputs high
    logic clear_on;            // both clears high and no preset
    logic force_on;            // any override of counting

    // edge detection: a high sample followed by a low one
    assign halve_fall = halve_prev_ff & ~halve_count_in;
    assign quint_fall = quint_prev_ff & ~quint_count_in;

    // gated overrides; preset beats clear
    assign preset_on = preset_nine_a & preset_nine_b;
    assign clear_on = clear_in_a & clear_in_b & ~preset_on;
    assign force_on = preset_on | clear_on;

    // next state of the stages and the input samples
    always_comb begin
        nxt_count = count_ff;
        nxt_halve_prev = halve_count_in;
        nxt_quint_prev = quint_count_in;
        if (preset_on) begin
            // load nine, ignoring count and clear inputs
            nxt_count = COUNT_NINE;
        end else if (clear_on) begin
            // force every stage low at once
            nxt_count = COUNT_ZERO;
        end else begin
            // halver toggles on its own input only
            if (halve_fall) begin
                nxt_count.halve = ~count_ff.halve;
            end
            // quint section steps on its own input only
            if (quint_fall) begin
                if (count_ff.quint >= QUINT_LAST) begin
                    // wrap after four; bcd nine goes to zero here
                    nxt_count.quint = QUINT_ZERO;
                end else begin
                    // binary step gives 8421 weights in bcd wiring
                    nxt_count.quint =
                        QUINT_W'(count_ff.quint + QUINT_STEP);
                end
            end
        end
    end

    // registers; all state frozen while the enable is low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= COUNT_ZERO;
            halve_prev_ff <= PREV_RESET;
            quint_prev_ff <= PREV_RESET;
        end else if (count_enable) begin
            count_ff <= nxt_count;
            halve_prev_ff <= nxt_halve_prev;
            quint_prev_ff <= nxt_quint_prev;
        end
    end

    // outputs straight from the stages; no internal ripple link
    assign halve_out = count_ff.halve;
    assign quint_bit_low = count_ff.quint[0];
    assign quint_bit_mid = count_ff.quint[1];
    assign quint_bit_high = count_ff.quint[2];

    // preset loads nine on the next edge
    property p_preset_nine;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && preset_on) |=> (count_ff == COUNT_NINE);
    endproperty
    a_preset_nine: assert property (p_preset_nine)
        else $error("preset did not load nine");

    // clear without preset zeroes all outputs
    property p_clear_zero;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && clear_in_a && clear_in_b && !preset_on)
            |=> (!halve_out && !quint_bit_low && !quint_bit_mid
                 && !quint_bit_high);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not zero the outputs");

    // halver keeps its value without a falling edge
    property p_halve_hold;
        @(posedge mclk) disable iff (!arst_n)
        (!force_on && !halve_fall) |=> $stable(halve_out);
    endproperty
    a_halve_hold: assert property (p_halve_hold)
        else $error("halver changed without a falling edge");

    // halver toggles after a falling edge of its input
    property p_halve_toggle;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && !force_on && !halve_prev_ff ##1
         halve_count_in && count_enable ##1
         !halve_count_in && !force_on && count_enable)
            |=> (halve_out != $past(halve_out));
    endproperty
    a_halve_toggle: assert property (p_halve_toggle)
        else $error("halver did not toggle on falling edge");

    // quint section ignores halver edges
    property p_quint_indep;
        @(posedge mclk) disable iff (!arst_n)
        (!force_on && halve_fall && !quint_fall)
            |=> $stable(count_ff.quint);
    endproperty
    a_quint_indep: assert property (p_quint_indep)
        else $error("quint section moved on a halver edge");

    // quint section wraps from four to zero
    property p_quint_wrap;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && !force_on && quint_fall
         && count_ff.quint == QUINT_LAST) |=> (count_ff.quint == QUINT_ZERO);
    endproperty
    a_quint_wrap: assert property (p_quint_wrap)
        else $error("quint section did not wrap after four");

    // quint section steps by one below four
    property p_quint_step;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && !force_on && quint_fall
         && count_ff.quint < QUINT_LAST)
            |=> (count_ff.quint == $past(count_ff.quint) + QUINT_STEP);
    endproperty
    a_quint_step: assert property (p_quint_step)
        else $error("quint section did not step by one");

    // quint section never leaves its five states
    property p_quint_range;
        @(posedge mclk) disable iff (!arst_n)
        count_ff.quint <= QUINT_LAST;
    endproperty
    a_quint_range: assert property (p_quint_range)
        else $error("quint section left its five states");

    // frozen enable holds every stage
    property p_enable_freeze;
        @(posedge mclk) disable iff (!arst_n)
        !count_enable |=> $stable(count_ff);
    endproperty
    a_enable_freeze: assert property (p_enable_freeze)
        else $error("stages changed while enable was low");

    // halver output moves only on its own fall or a force
    property p_halve_cause;
        @(posedge mclk) disable iff (!arst_n)
        $changed(halve_out)
            |-> (($past(halve_fall) || $past(force_on)) && $past(count_enable));
    endproperty
    a_halve_cause: assert property (p_halve_cause)
        else $error("halver moved without a cause");

    // halver output falls every second count, the bcd quint clock
    property p_halve_carry;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && !force_on && halve_fall && halve_out)
            |=> $fell(halve_out);
    endproperty
    a_halve_carry: assert property (p_halve_carry)
        else $error("halver output did not fall on its carry");

    // wrap of the quint section drops the high bit, the bi-quinary clock
    property p_quint_carry;
        @(posedge mclk) disable iff (!arst_n)
        (count_enable && !force_on && quint_fall
         && count_ff.quint == QUINT_LAST) |=> $fell(quint_bit_high);
    endproperty
    a_quint_carry: assert property (p_quint_carry)
        else $error("high bit did not fall on the quint wrap");

    // quint section keeps its value without a falling edge
    property p_quint_hold;
        @(posedge mclk) disable iff (!arst_n)
        (!force_on && !quint_fall) |=> $stable(count_ff.quint);
    endproperty
    a_quint_hold: assert property (p_quint_hold)
        else $error("quint section changed without a falling edge");

endmodule : ripple_decade_counter

// ---- test/count_wiring.sv ----
// far-side model: count pulse source and external mode wiring
`timescale 1ns/10ps
module count_wiring (
    // mode: 0 bcd, 1 bi-quinary, 2 both on pulse, 3 quint only
    input wire logic [1:0] mode,
    input wire logic pulse,
    // counter outputs fed back
    input wire logic halve_out,
    input wire logic quint_bit_high,
    // count inputs of the counter
    output logic halve_count_in,
    output logic quint_count_in
);
    // outputs only wired through, never decoded as clocks
    always_comb begin
        halve_count_in = pulse;
        quint_count_in = pulse;
        if (mode == 2'h0) begin
            quint_count_in = halve_out;
        end else if (mode == 2'h1) begin
            halve_count_in = quint_bit_high;
        end else if (mode == 2'h3) begin
            halve_count_in = 1'b0; // halver left idle
        end
    end
endmodule : count_wiring

// ---- test/ripple_decade_counter_bench.sv ----
// self-checking bench for the ripple decade counter
`timescale 1ns/10ps
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin fails++; \
    $display("MISMATCH %0t got %h want %h", $time, g, w); end end
module ripple_decade_counter_bench;
    import decade_pkg::*;
    // one row: mode, pulse count, expected {high, mid, low, halve}
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] n;
        logic [3:0] want;
    } row_t;
    row_t rows [10] = '{{2'h0, 4'h6, 4'h6}, {2'h0, 4'h7, 4'h7},
        {2'h0, 4'h9, 4'h9}, {2'h0, 4'ha, 4'h0}, {2'h1, 4'h4, 4'h8},
        {2'h1, 4'h5, 4'h1}, {2'h1, 4'h9, 4'h9}, {2'h2, 4'h3, 4'h7},
        {2'h2, 4'h5, 4'h1}, {2'h2, 4'h6, 4'h2}};
    logic mclk = 1'b0, arst_n = 1'b0, count_enable = 1'b1, pulse = 1'b0;
    logic clear_in_a = 1'b0, clear_in_b = 1'b0;
    logic preset_nine_a = 1'b0, preset_nine_b = 1'b0;
    logic [1:0] mode = 2'h0;
    logic halve_count_in, quint_count_in, halve_out;
    logic quint_bit_low, quint_bit_mid, quint_bit_high;
    int fails = 0, num_checks = 0;
    wire logic [3:0] q = {quint_bit_high, quint_bit_mid, quint_bit_low,
                          halve_out};
    // 50 mhz clock
    always #10 mclk = ~mclk;
    ripple_decade_counter dut (.mclk, .arst_n, .count_enable,
        .halve_count_in, .quint_count_in, .clear_in_a, .clear_in_b,
        .preset_nine_a, .preset_nine_b, .halve_out, .quint_bit_low,
        .quint_bit_mid, .quint_bit_high);
    count_wiring wiring (.mode, .pulse, .halve_out, .quint_bit_high,
        .halve_count_in, .quint_count_in);
    // wait whole cycles, landing on a falling edge
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask : tick
    // full count pulses, two cycles high, three low for the ripple
    task automatic pulses(input int k);
        repeat (k) begin
            pulse = 1'b1;
            tick(2);
            pulse = 1'b0;
            tick(3);
        end
    endtask : pulses
    // apply {clear a, clear b, preset a, preset b} for two cycles
    task automatic force_lv(input logic [3:0] lv);
        {clear_in_a, clear_in_b, preset_nine_a, preset_nine_b} = lv;
        tick(2);
        {clear_in_a, clear_in_b, preset_nine_a, preset_nine_b} = 4'h0;
        tick(2);
    endtask : force_lv
    // verdict and end of run
    task automatic results;
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // main sequence
    initial begin
        tick(6);
        arst_n = 1'b1;
        tick(1);
        `CHK(q, 4'h0)
        foreach (rows[i]) begin
            mode = rows[i].mode;
            force_lv(4'hc);
            pulses(int'(rows[i].n));
            `CHK(q, rows[i].want)
        end
        // preset beats clear, clear with a lone preset
        force_lv(4'hf);
        `CHK(q, 4'h9)
        force_lv(4'he);
        `CHK(q, 4'h0)
        // one clear input alone does not clear
        pulses(1);
        force_lv(4'h8);
        `CHK(q, 4'h3)
        // quint pulses leave the halver alone
        mode = 2'h3;
        pulses(2);
        `CHK(q, 4'h7)
        // disabled: nothing sampled
        count_enable = 1'b0;
        pulses(1);
        count_enable = 1'b1;
        `CHK(q, 4'h7)
        // rising edge does nothing, falling edge counts
        pulse = 1'b1;
        tick(3);
        `CHK(q, 4'h7)
        pulse = 1'b0;
        tick(3);
        `CHK(q, 4'h9)
        // pulse during clear is lost
        {clear_in_a, clear_in_b} = 2'h3;
        pulses(1);
        {clear_in_a, clear_in_b} = 2'h0;
        tick(1);
        `CHK(q, 4'h0)
        // reset in mid-run
        pulses(1);
        arst_n = 1'b0;
        tick(2);
        `CHK(q, 4'h0)
        arst_n = 1'b1;
        tick(1);
        `CHK(q, 4'h0)
        pulses(1);
        `CHK(q, 4'h2)
        results();
    end
    // watchdog against a hang
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule : ripple_decade_counter_bench
